/* shared/bos_pkg.sv */
// Purpose: Constants, register map and state type of the burst output sequencer
// Assumes: One output sample per detected rising edge of the sample clock
// Notes:   Sample counts are in output samples, not in system clock cycles
// Operation
// - After burst enable, 2^13 low-resolution samples come before any burst
// - Burst requests are ignored during that first low-resolution period
// - Ready flag rises when it ends; a rising request then starts a burst
// - Burst request is sampled on every rising edge of the sample clock
// - First high-resolution sample follows an accepted request by 1-2 DDR cycles
// - High-resolution flag marks exactly the 2^N burst samples, then falls
// - After a burst, N is re-read and 2^(N+3) low samples follow, requests ignored
// - In manual mode the ready flag rises again after the lockout
// - Auto mode starts each burst by itself after the low-resolution period
// - Auto mode ignores requests and pulses ready one cycle per burst start
// - Burst exponent N is held within 10 to 25
// - Full-speed low resolution keeps 7 MSBs at the full sample rate
// - Decimated low resolution keeps 11 MSBs, each kept sample shown four times
// - Decimated output keeps the high-resolution latency at the sample rate
// - First registered align edge resets logic and starts a 32-sample marker
// - After alignment the output is flagged invalid for 36 samples
// - Marker starts on the align sample itself, with the DDR output clock driven high
// - Align edge off the current marker phase restarts the counter there
// - Alignment on a falling-edge sample stretches the DDR clock half a cycle
// - Frame marker is presented on frameMarkerOut, beside the converted sample bus
// - N resets to ten; a change applies from the next low-resolution period
package bos_pkg;
	localparam int SAMPLE_W = 12;
	localparam int EXP_W    = 5;
	localparam int CNT_W    = 29;
	localparam int MARK_W   = 5;
	localparam int INV_W    = 6;
	localparam int RD_W     = 32;

	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_EXP  = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;

	// Control and status fields
	localparam int CTRL_BURST   = 0;
	localparam int CTRL_AUTO    = 1;
	localparam int CTRL_DEC     = 2;
	localparam int STAT_READY   = 0;
	localparam int STAT_HIGH    = 1;
	localparam int STAT_MARK    = 2;
	localparam int STAT_VALID   = 3;
	localparam int STAT_ALIGNED = 4;
	localparam int STAT_EXP_LSB = 8;

	// Synchroniser bit positions
	localparam int SYN_SCLK  = 0;
	localparam int SYN_TRIG  = 1;
	localparam int SYN_ALIGN = 2;
	localparam int SYN_DATA  = 3;

	localparam logic [EXP_W-1:0]    EXP_RESET   = 5'h0a;
	localparam logic [EXP_W-1:0]    EXP_MIN     = 5'h0a;
	localparam logic [EXP_W-1:0]    EXP_MAX     = 5'h19;
	localparam logic [EXP_W-1:0]    EXP_INIT    = 5'h0d;
	localparam logic [EXP_W-1:0]    EXP_LOW_ADD = 5'h03;
	localparam logic [CNT_W-1:0]    CNT_ONE     = 29'h0000001;
	localparam logic                WAIT_LAST   = 1'h1;
	localparam logic [MARK_W-1:0]   MARK_LAST   = 5'h1f;
	localparam logic [INV_W-1:0]    INV_LOAD    = 6'h24;
	localparam logic [SAMPLE_W-1:0] LOW_FULL_MASK = 12'hfe0;
	localparam logic [SAMPLE_W-1:0] LOW_DEC_MASK  = 12'hffe;
	localparam logic [1:0]          DEC_FIRST   = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INIT,
		ST_READY,
		ST_TWAIT,
		ST_HIGH,
		ST_LOCK
	} bos_state_t;
endpackage

/* shared/bos_link_if.sv */
// Purpose: Link between the sequencer and its alignment unit
// Assumes: All signals on the system clock
// Notes:   sampleTick is a one-cycle pulse per sample
interface bos_link_if;
	logic sampleTick;
	logic alignLevel;
	logic alignReset;
	logic ddrClk;
	logic frameMarker;
	logic dataValid;
	logic aligned;

	modport seq (output sampleTick, output alignLevel, input alignReset,
		input ddrClk, input frameMarker, input dataValid, input aligned);
	modport aln (input sampleTick, input alignLevel, output alignReset,
		output ddrClk, output frameMarker, output dataValid, output aligned);
endinterface

/* logic/bos_align.sv */
// Purpose: Alignment unit: frame marker counter, DDR clock and invalid window
// Assumes: alignLevel is already synchronised; sampleTick marks each sample
// Notes:   A periodic align pulse at the running phase changes nothing
module bos_align (
	input logic clk,
	input logic resetn,
	bos_link_if.aln link
);
	import bos_pkg::*;

	logic              alignPrev_r;
	logic              started_r;
	logic              ddrClk_r;
	logic              marker_r;
	logic              alignReset_r;
	logic [MARK_W-1:0] phase_r;
	logic [INV_W-1:0]  invalid_r;
	logic              alignEdge;
	logic              realign;

	// Edge registered at a sample; off-phase or first edge realigns
	assign alignEdge = link.sampleTick & link.alignLevel & ~alignPrev_r;
	assign realign   = alignEdge & (~started_r | (phase_r != MARK_LAST));

	// Align edge history, sampled per sample
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alignPrev_r <= 1'b0;
		end else if (link.sampleTick) begin
			alignPrev_r <= link.alignLevel;
		end
	end

	// Marker phase, DDR clock and invalid window
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			started_r    <= 1'b0;
			ddrClk_r     <= 1'b0;
			marker_r     <= 1'b0;
			alignReset_r <= 1'b0;
			phase_r      <= '0;
			invalid_r    <= '0;
		end else begin
			alignReset_r <= realign;
			if (realign) begin
				started_r <= 1'b1;
				phase_r   <= '0;
				ddrClk_r  <= 1'b1;
				marker_r  <= 1'b1;
				invalid_r <= INV_LOAD;
			end else if (link.sampleTick) begin
				phase_r  <= phase_r + 5'h01;
				ddrClk_r <= ~ddrClk_r;
				marker_r <= started_r & (phase_r == MARK_LAST);
				if (invalid_r != '0) begin
					invalid_r <= invalid_r - 6'h01;
				end
			end
		end
	end

	assign link.alignReset  = alignReset_r;
	assign link.ddrClk      = ddrClk_r;
	assign link.frameMarker = marker_r;
	assign link.dataValid   = (invalid_r == '0);
	assign link.aligned     = started_r;

	AST_MARK_WRAP: assert property (@(posedge clk) disable iff (!resetn)
		(link.sampleTick && started_r && phase_r == MARK_LAST && !alignEdge)
		|=> (marker_r && phase_r == '0))
		else $error("marker did not wrap after 32 samples");
	AST_INVALID: assert property (@(posedge clk) disable iff (!resetn)
		realign |=> (invalid_r == INV_LOAD && !link.dataValid))
		else $error("invalid window not loaded with 36");
	AST_STRETCH: assert property (@(posedge clk) disable iff (!resetn)
		(realign && ddrClk_r) |=> (ddrClk_r && marker_r))
		else $error("DDR clock not stretched at alignment");
	AST_REALIGN: assert property (@(posedge clk) disable iff (!resetn)
		(alignEdge && started_r && phase_r != MARK_LAST) |=> alignReset_r)
		else $error("off-phase align edge ignored");
endmodule

/* logic/bos_sequencer.sv */
// Purpose: Burst output sequencer with Avalon-MM control registers
// Assumes: Sample clock is slower than a quarter of clk; bus driven on clk
// Notes:   Low, burst and lockout lengths are counted in output samples
module bos_sequencer #(
	parameter logic [4:0] INIT_LOW_EXP = bos_pkg::EXP_INIT
) (
	input  logic                         clk,
	input  logic                         resetn,
	input  logic [3:0]                   avsAddress,
	input  logic                         avsRead,
	input  logic                         avsWrite,
	input  logic [bos_pkg::RD_W-1:0]     avsWritedata,
	input  logic [3:0]                   avsByteenable,
	output logic [bos_pkg::RD_W-1:0]     avsReaddata,
	output logic                         avsWaitrequest,
	input  logic                         sampleClockIn,
	input  logic                         burstRequestIn,
	input  logic                         alignPulseIn,
	input  logic [bos_pkg::SAMPLE_W-1:0] adcSampleIn,
	output logic [bos_pkg::SAMPLE_W-1:0] convertedSampleBus,
	output logic                         triggerReadyFlag,
	output logic                         highResFlag,
	output logic                         frameMarkerOut,
	output logic                         outputDdrClock,
	output logic                         dataValid
);
	import bos_pkg::*;

	localparam int SYN_W = SAMPLE_W + SYN_DATA;

	bos_link_if link ();

	logic [SYN_W-1:0]    synA_r;
	logic [SYN_W-1:0]    synB_r;
	logic                sclkPrev_r;
	logic                trigPrev_r;
	logic                sampleTick;
	logic                trigEdge;
	logic [SAMPLE_W-1:0] adcNow;

	// Two-flop synchronisers for all inputs from the sample domain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			synA_r <= '0;
			synB_r <= '0;
		end else begin
			synA_r <= {adcSampleIn, alignPulseIn, burstRequestIn, sampleClockIn};
			synB_r <= synA_r;
		end
	end

	// Sample clock edge finder and request history
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_r <= 1'b0;
			trigPrev_r <= 1'b0;
		end else begin
			sclkPrev_r <= synB_r[SYN_SCLK];
			if (sampleTick) begin
				trigPrev_r <= synB_r[SYN_TRIG];
			end
		end
	end

	assign sampleTick      = synB_r[SYN_SCLK] & ~sclkPrev_r;
	assign trigEdge        = sampleTick & synB_r[SYN_TRIG] & ~trigPrev_r;
	assign adcNow          = synB_r[SYN_W-1:SYN_DATA];
	assign link.sampleTick = sampleTick;
	assign link.alignLevel = synB_r[SYN_ALIGN];

	bos_align u_align (
		.clk    (clk),
		.resetn (resetn),
		.link   (link)
	);

	// Register bus
	logic                ackR_r;
	logic [RD_W-1:0]     readdata_r;
	logic [RD_W-1:0]     rdMux;
	logic                burstEn_r;
	logic                autoTrig_r;
	logic                decLow_r;
	logic [EXP_W-1:0]    expReg_r;
	logic [EXP_W-1:0]    expIn;
	logic [EXP_W-1:0]    expUsed_r;
	logic                readyOut_r;
	logic                highOut_r;
	logic                wrTake;

	// One wait cycle on every access
	assign avsWaitrequest = (avsRead | avsWrite) & ~ackR_r;
	assign wrTake         = avsWrite & ackR_r & avsByteenable[0];
	assign expIn          = avsWritedata[EXP_W-1:0];
	assign avsReaddata    = readdata_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ackR_r <= 1'b0;
		end else begin
			ackR_r <= (avsRead | avsWrite) & ~ackR_r;
		end
	end

	// Control writes; exponent clamped into its legal range
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			burstEn_r  <= 1'b0;
			autoTrig_r <= 1'b0;
			decLow_r   <= 1'b0;
			expReg_r   <= EXP_RESET;
		end else if (wrTake) begin
			if (avsAddress == REG_CTRL) begin
				burstEn_r  <= avsWritedata[CTRL_BURST];
				autoTrig_r <= avsWritedata[CTRL_AUTO];
				decLow_r   <= avsWritedata[CTRL_DEC];
			end
			if (avsAddress == REG_EXP) begin
				if (expIn < EXP_MIN) begin
					expReg_r <= EXP_MIN;
				end else if (expIn > EXP_MAX) begin
					expReg_r <= EXP_MAX;
				end else begin
					expReg_r <= expIn;
				end
			end
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		rdMux = '0;
		case (avsAddress)
			REG_CTRL: begin
				rdMux[CTRL_BURST] = burstEn_r;
				rdMux[CTRL_AUTO]  = autoTrig_r;
				rdMux[CTRL_DEC]   = decLow_r;
			end
			REG_EXP: begin
				rdMux[EXP_W-1:0] = expReg_r;
			end
			REG_STAT: begin
				rdMux[STAT_READY]   = readyOut_r;
				rdMux[STAT_HIGH]    = highOut_r;
				rdMux[STAT_MARK]    = link.frameMarker;
				rdMux[STAT_VALID]   = link.dataValid;
				rdMux[STAT_ALIGNED] = link.aligned;
				rdMux[STAT_EXP_LSB +: EXP_W] = expUsed_r;
			end
			default: begin
				rdMux = '0;
			end
		endcase
	end

	// Read data captured in the wait cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readdata_r <= '0;
		end else if (avsRead && !ackR_r) begin
			readdata_r <= rdMux;
		end
	end

	// Burst sequence
	bos_state_t       state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] curLimit;
	logic             waitCnt_r;
	logic             autoPulse_r;
	logic             cntDone;
	logic             lowState;

	// Last count of the current period
	always_comb begin
		curLimit = '0;
		case (state_r)
			ST_INIT: curLimit = (CNT_ONE << INIT_LOW_EXP) - CNT_ONE;
			ST_HIGH: curLimit = (CNT_ONE << expUsed_r) - CNT_ONE;
			ST_LOCK: curLimit = (CNT_ONE << EXP_W'(expUsed_r + EXP_LOW_ADD)) - CNT_ONE;
			default: curLimit = '0;
		endcase
	end

	assign cntDone  = (cnt_r == curLimit);
	assign lowState = (state_r != ST_HIGH) && (state_r != ST_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_IDLE;
			cnt_r       <= '0;
			waitCnt_r   <= 1'b0;
			autoPulse_r <= 1'b0;
			expUsed_r   <= EXP_RESET;
		end else begin
			autoPulse_r <= 1'b0;
			if (!burstEn_r) begin
				state_r <= ST_IDLE;
				cnt_r   <= '0;
			end else if (link.alignReset || state_r == ST_IDLE) begin
				state_r   <= ST_INIT;
				cnt_r     <= '0;
				expUsed_r <= expReg_r;
			end else if (state_r == ST_READY && autoTrig_r) begin
				state_r     <= ST_HIGH;
				autoPulse_r <= 1'b1;
			end else if (sampleTick) begin
				case (state_r)
					ST_INIT, ST_LOCK: begin
						if (cntDone) begin
							cnt_r <= '0;
							if (autoTrig_r) begin
								state_r     <= ST_HIGH;
								autoPulse_r <= 1'b1;
							end else begin
								state_r <= ST_READY;
							end
						end else begin
							cnt_r <= cnt_r + CNT_ONE;
						end
					end
					ST_READY: begin
						if (trigEdge) begin
							state_r   <= ST_TWAIT;
							waitCnt_r <= 1'b0;
						end
					end
					ST_TWAIT: begin
						if (waitCnt_r == WAIT_LAST) begin
							state_r <= ST_HIGH;
						end else begin
							waitCnt_r <= waitCnt_r + 1'b1;
						end
					end
					ST_HIGH: begin
						if (cntDone) begin
							cnt_r     <= '0;
							state_r   <= ST_LOCK;
							expUsed_r <= expReg_r;
						end else begin
							cnt_r <= cnt_r + CNT_ONE;
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Ready flag: level in manual mode, one-cycle pulse in auto mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readyOut_r <= 1'b0;
		end else begin
			readyOut_r <= (state_r == ST_READY && !autoTrig_r) | autoPulse_r;
		end
	end

	// Output data path, one update per sample
	logic [SAMPLE_W-1:0] dataOut_r;
	logic [SAMPLE_W-1:0] decHold_r;
	logic [1:0]          decPhase_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dataOut_r  <= '0;
			decHold_r  <= '0;
			decPhase_r <= DEC_FIRST;
			highOut_r  <= 1'b0;
		end else if (link.alignReset) begin
			decPhase_r <= DEC_FIRST;
		end else if (sampleTick) begin
			decPhase_r <= decPhase_r + 2'h1;
			highOut_r  <= (state_r == ST_HIGH);
			if (!lowState) begin
				dataOut_r <= adcNow;
			end else if (decLow_r) begin
				if (decPhase_r == DEC_FIRST) begin
					dataOut_r <= adcNow & LOW_DEC_MASK;
					decHold_r <= adcNow & LOW_DEC_MASK;
				end else begin
					dataOut_r <= decHold_r;
				end
			end else begin
				dataOut_r <= adcNow & LOW_FULL_MASK;
			end
		end
	end

	assign convertedSampleBus = dataOut_r;
	assign highResFlag        = highOut_r;
	assign triggerReadyFlag   = readyOut_r;
	assign frameMarkerOut     = link.frameMarker;
	assign outputDdrClock     = link.ddrClk;
	assign dataValid          = link.dataValid;

	// Helper: length of the last flagged burst
	logic [CNT_W-1:0] hrCnt_r;
	logic [EXP_W-1:0] hrExp_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrCnt_r <= '0;
			hrExp_r <= EXP_RESET;
		end else if (sampleTick) begin
			hrCnt_r <= highOut_r ? hrCnt_r + CNT_ONE : '0;
			if (!highOut_r) begin
				hrExp_r <= expUsed_r;
			end
		end
	end

	AST_INIT_IGNORE: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_INIT && trigEdge && burstEn_r && !link.alignReset)
		|=> (state_r == ST_INIT || state_r == ST_READY || state_r == ST_HIGH))
		else $error("request acted on during initial low period");
	AST_INIT_DONE: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_INIT && sampleTick && cntDone && burstEn_r
		&& !link.alignReset && !autoTrig_r) |=> (state_r == ST_READY) ##1 readyOut_r)
		else $error("ready not raised after initial low period");
	AST_TRIG_TAKEN: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_READY && !autoTrig_r && trigEdge && burstEn_r && !link.alignReset)
		|=> (state_r == ST_TWAIT))
		else $error("rising request not accepted");
	AST_TRIG_DELAY: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_READY && !autoTrig_r && trigEdge && burstEn_r && !link.alignReset)
		|-> !highOut_r [*2] ##[1:40] highOut_r)
		else $error("burst did not start within two DDR cycles");
	AST_HIGH_RES_FLAG_LEN: assert property (@(posedge clk) disable iff (!resetn)
		($fell(highOut_r) && state_r == ST_LOCK) |-> (hrCnt_r == (CNT_ONE << hrExp_r)))
		else $error("high-resolution flag length is not 2^N");
	AST_LOCK_START: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_HIGH && sampleTick && cntDone && burstEn_r && !link.alignReset)
		|=> (state_r == ST_LOCK && cnt_r == '0 && expUsed_r == $past(expReg_r)))
		else $error("lockout did not follow burst with re-read N");
	AST_READY_AGAIN: assert property (@(posedge clk) disable iff (!resetn)
		(state_r == ST_LOCK && sampleTick && cntDone && burstEn_r
		&& !link.alignReset && !autoTrig_r) |=> ##1 readyOut_r)
		else $error("ready not raised after lockout");
	AST_AUTO_START: assert property (@(posedge clk) disable iff (!resetn)
		((state_r == ST_INIT || state_r == ST_LOCK) && sampleTick && cntDone && autoTrig_r
		&& burstEn_r && !link.alignReset) |=> (state_r == ST_HIGH))
		else $error("auto mode did not start burst");
	AST_AUTO_PULSE: assert property (@(posedge clk) disable iff (!resetn)
		(autoTrig_r && $rose(readyOut_r)) |=> !readyOut_r)
		else $error("auto ready pulse longer than one cycle");
	AST_EXP_RANGE: assert property (@(posedge clk) disable iff (!resetn)
		(expReg_r >= EXP_MIN && expReg_r <= EXP_MAX && expUsed_r >= EXP_MIN))
		else $error("burst exponent out of range");
	AST_LOW_FULL: assert property (@(posedge clk) disable iff (!resetn)
		(sampleTick && lowState && !decLow_r && !link.alignReset)
		|=> ((dataOut_r & ~LOW_FULL_MASK) == '0))
		else $error("full-speed low sample carries more than 7 bits");
	AST_DEC_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		(sampleTick && lowState && decLow_r && decPhase_r != DEC_FIRST && !link.alignReset)
		|=> (dataOut_r == $past(decHold_r) && (dataOut_r & ~LOW_DEC_MASK) == '0))
		else $error("decimated sample not repeated");
endmodule

/* testbench/bos_rx_model.sv */
// Purpose: Far-side model: sample source and DDR data receiver
// Assumes: One output sample per edge of outputDdrClock
// Notes:   Counts samples, burst samples and marker spacing
module bos_rx_model (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic outputDdrClock,
	input  wire logic highResFlag,
	input  wire logic frameMarkerOut,
	output logic      sampleClockIn,
	output logic [11:0] adcSampleIn,
	output int        sampleCnt,
	output int        hiCnt,
	output int        markGap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       ddrPrev;
	logic [1:0] divCnt;
	int         sinceMark;
	// Sample clock of 320 ns: toggles on every fourth rising edge of clk
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			divCnt        <= 2'h0;
			sampleClockIn <= 1'b0;
		end else begin
			divCnt <= divCnt + 2'h1;
			if (divCnt == 2'h3) begin
				sampleClockIn <= ~sampleClockIn;
			end
		end
	end
	// Fixed converter value, so every output form is known in advance
	assign adcSampleIn = 12'hb7d;
	// Capture one sample per DDR clock edge, count burst samples and marker gaps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ddrPrev <= 1'b0;
			sampleCnt <= 0;
			hiCnt <= 0;
			markGap <= 0;
			sinceMark <= 0;
		end else begin
			ddrPrev <= outputDdrClock;
			if (outputDdrClock != ddrPrev) begin
				sampleCnt <= sampleCnt + 1;
				if (highResFlag) hiCnt <= hiCnt + 1;
				sinceMark <= frameMarkerOut ? 1 : sinceMark + 1;
				if (frameMarkerOut) markGap <= sinceMark;
			end
		end
	end
endmodule

/* testbench/burst_output_sequencer_test.sv */
// Purpose: Self-checking bench of the burst output sequencer
// Assumes: Initial low period shortened to 16 samples, N kept at 10
// Notes:   Sample clock of 320 ns gives eight clk cycles per sample
module burst_output_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import bos_pkg::*;
	logic        clk, resetn, avsRead, avsWrite, burstRequestIn, alignPulseIn;
	logic [3:0]  avsAddress, avsByteenable;
	logic [31:0] avsWritedata, avsReaddata, rd;
	logic        avsWaitrequest, sampleClockIn, triggerReadyFlag, highResFlag;
	logic        frameMarkerOut, outputDdrClock, dataValid;
	logic [11:0] adcSampleIn, convertedSampleBus;
	int          badCount, checksDone, sampleCnt, hiCnt, markGap, t, base, hi0;
	bos_sequencer #(.INIT_LOW_EXP(5'h04)) dut (.clk(clk), .resetn(resetn),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.sampleClockIn(sampleClockIn), .burstRequestIn(burstRequestIn),
		.alignPulseIn(alignPulseIn), .adcSampleIn(adcSampleIn),
		.convertedSampleBus(convertedSampleBus), .triggerReadyFlag(triggerReadyFlag),
		.highResFlag(highResFlag), .frameMarkerOut(frameMarkerOut),
		.outputDdrClock(outputDdrClock), .dataValid(dataValid));
	bos_rx_model rx (.clk(clk), .resetn(resetn), .outputDdrClock(outputDdrClock),
		.highResFlag(highResFlag), .frameMarkerOut(frameMarkerOut),
		.sampleClockIn(sampleClockIn), .adcSampleIn(adcSampleIn),
		.sampleCnt(sampleCnt), .hiCnt(hiCnt), .markGap(markGap));
	// System clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Print the verdict and end the run
	task automatic giveVerdict();
		if (badCount == 0 && checksDone > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= wr;
		avsRead <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 50);
		q = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		if (n >= 50) begin
			badCount++;
			giveVerdict();
		end
	endtask
	// Current level of one watched output
	function automatic logic pick(input int s);
		case (s)
			0: return triggerReadyFlag;
			1: return highResFlag;
			2: return frameMarkerOut;
			default: return dataValid;
		endcase
	endfunction
	// Bounded wait for an output level; returns the samples passed
	task automatic waitFor(input int s, input logic lvl, input int maxClk, output int ticks);
		int t0;
		int i;
		t0 = sampleCnt;
		i = 0;
		while (pick(s) !== lvl && i < maxClk) begin
			@(posedge clk);
			i++;
		end
		ticks = sampleCnt - t0;
		if (pick(s) !== lvl) begin
			badCount++;
			giveVerdict();
		end
	endtask
	// Let a number of samples pass
	task automatic waitTicks(input int n);
		int w;
		w = 0;
		waitFor(2, frameMarkerOut, 1, w);
		for (int i = 0; i < n * 8; i++) @(posedge clk);
	endtask
	// Reset values, exponent clamping and an unmapped address
	task automatic sRegs();
		bus(1'b0, REG_EXP, 32'h0, rd);
		check("exp reset", rd, 32'h0000000a);
		bus(1'b1, REG_EXP, 32'h5, rd);
		bus(1'b0, REG_EXP, 32'h0, rd);
		check("exp low clamp", rd, 32'h0000000a);
		bus(1'b1, REG_EXP, 32'h1f, rd);
		bus(1'b0, REG_EXP, 32'h0, rd);
		check("exp high clamp", rd, 32'h00000019);
		bus(1'b1, REG_EXP, 32'ha, rd);
		bus(1'b0, 4'hc, 32'h0, rd);
		check("unmapped read", rd, 32'h0);
		bus(1'b0, REG_CTRL, 32'h0, rd);
		check("ctrl reset", rd, 32'h0);
	endtask
	// Manual trigger: initial period, burst, lockout and re-arm
	task automatic sManual();
		hi0 = hiCnt;
		bus(1'b1, REG_CTRL, 32'h1, rd);
		base = sampleCnt;
		waitTicks(2);
		burstRequestIn <= 1'b1;
		waitTicks(2);
		burstRequestIn <= 1'b0;
		waitFor(0, 1'b1, 400, t);
		t = sampleCnt - base;
		check("init length", {31'h0, t >= 15 && t <= 18}, 32'h1);
		check("init ignores request", hiCnt, hi0);
		check("low full data", convertedSampleBus, 12'hb60);
		bus(1'b0, REG_STAT, 32'h0, rd);
		check("stat ready and n", rd & 32'h1f01, 32'h0a01);
		burstRequestIn <= 1'b1;
		waitFor(1, 1'b1, 80, t);
		burstRequestIn <= 1'b0;
		check("trigger delay", {31'h0, t >= 2 && t <= 4}, 32'h1);
		check("high data", convertedSampleBus, 12'hb7d);
		hi0 = hiCnt;
		waitFor(1, 1'b0, 9000, t);
		check("burst length", hiCnt - hi0, 32'd1024);
		check("lockout ready", triggerReadyFlag, 1'b0);
		check("lockout data", convertedSampleBus, 12'hb60);
		base = sampleCnt;
		hi0 = hiCnt;
		waitTicks(20);
		burstRequestIn <= 1'b1;
		waitTicks(2);
		burstRequestIn <= 1'b0;
		waitFor(0, 1'b1, 70000, t);
		check("lockout length", sampleCnt - base, 32'd8192);
		check("lockout ignores request", hiCnt, hi0);
		bus(1'b1, REG_CTRL, 32'h5, rd);
		waitTicks(6);
		check("decimated data", convertedSampleBus, 12'hb7c);
		bus(1'b1, REG_CTRL, 32'h0, rd);
		waitTicks(3);
		check("idle data", convertedSampleBus, 12'hb7d);
		check("idle flags", {triggerReadyFlag, highResFlag}, 2'b00);
	endtask
	// Automatic trigger: one-cycle ready pulse and a 2^N burst
	task automatic sAuto();
		bus(1'b1, REG_CTRL, 32'h3, rd);
		burstRequestIn <= 1'b1;
		waitFor(0, 1'b1, 400, t);
		@(posedge clk);
		check("auto ready pulse", triggerReadyFlag, 1'b0);
		burstRequestIn <= 1'b0;
		waitFor(1, 1'b1, 40, t);
		hi0 = hiCnt;
		waitFor(1, 1'b0, 9000, t);
		check("auto burst length", hiCnt - hi0, 32'd1024);
		bus(1'b1, REG_CTRL, 32'h0, rd);
	endtask
	// Alignment: marker, invalid window and realignment off phase
	task automatic sAlign();
		alignPulseIn <= 1'b1;
		waitFor(2, 1'b1, 200, t);
		alignPulseIn <= 1'b0;
		check("align clock", outputDdrClock, 1'b1);
		check("align invalid", dataValid, 1'b0);
		base = sampleCnt;
		waitFor(3, 1'b1, 600, t);
		t = sampleCnt - base;
		check("invalid length", {31'h0, t >= 35 && t <= 36}, 32'h1);
		waitTicks(40);
		check("marker period", markGap, 32'd32);
		waitFor(2, 1'b1, 400, t);
		waitTicks(8);
		alignPulseIn <= 1'b1;
		waitFor(2, 1'b1, 60, t);
		alignPulseIn <= 1'b0;
		check("realign invalid", dataValid, 1'b0);
	endtask
	// Reset, then the scenarios in order
	initial begin
		badCount = 0;
		checksDone = 0;
		resetn = 1'b0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddress = 4'h0;
		avsWritedata = 32'h0;
		avsByteenable = 4'hf;
		burstRequestIn = 1'b0;
		alignPulseIn = 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		sRegs();
		sManual();
		sAuto();
		sAlign();
		giveVerdict();
	end
endmodule
